// ===== dv/crd_mech.sv
// card mechanism model: card arrival, column strobe and stacker pass
`timescale 1ns/1ps
`default_nettype none
module crd_mech (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic feed_clutch,
  input wire logic [7:0] arrive_dly,
  input wire logic [11:0] punch,
  output logic card_at_station,
  output logic card_passed,
  output logic col_strobe,
  output logic [11:0] col_punch
);
  logic [7:0] cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 8'h00;
      card_at_station <= 1'b0;
      card_passed <= 1'b0;
      col_strobe <= 1'b0;
      col_punch <= 12'h000;
    end else begin
      card_passed <= 1'b0;
      col_strobe <= 1'b0;
      // punch lines are not held outside the strobe cycle
      col_punch <= ~col_punch;
      if (card_at_station) begin
        cnt <= cnt + 8'h01;
        if (cnt == 8'h02) begin
          col_strobe <= 1'b1;
          col_punch <= punch;
        end
        if (cnt == 8'h05) begin
          card_passed <= 1'b1;
          card_at_station <= 1'b0;
          cnt <= 8'h00;
        end
      end else if (feed_clutch && arrive_dly != 8'h00) begin
        // zero delay means the card never arrives
        cnt <= cnt + 8'h01;
        if (cnt + 8'h01 == arrive_dly) begin
          card_at_station <= 1'b1;
          cnt <= 8'h00;
        end
      end else begin
        cnt <= 8'h00;
      end
    end
  end
endmodule : crd_mech
`default_nettype wire

// ===== dv/test_card_reader_status_control.sv
// self-checking testbench of the card reader control block
`timescale 1ns/1ps
`default_nettype none
module test_card_reader_status_control;
  import crd_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, irq, ru, ccv;
  logic m_at, m_pass, m_strb;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [11:0] col_char, m_punch, mp, c;
  logic [7:0] ad;
  logic [5:0] pnl;
  crd_sense_t sn, sw;
  crd_drive_t drive;
  int n_fail, comparisons, i;

  always_comb begin
    sw = sn;
    sw.card_at_station = m_at;
    sw.card_passed = m_pass;
  end

  crd_ctrl #(.PWRUP_CYC(10), .FEED_CYC(20)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hsize(hsize), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata),
    .panel(crd_panel_t'(pnl)), .sense(sw), .col_strobe(m_strb),
    .col_punch(m_punch), .col_char(col_char), .col_char_valid(ccv),
    .drive(drive), .reader_unavailable(ru), .irq(irq));

  crd_mech u_mech (.hclk(hclk), .hresetn(hresetn),
    .feed_clutch(drive.feed_clutch), .arrive_dly(ad), .punch(mp),
    .card_at_station(m_at), .card_passed(m_pass), .col_strobe(m_strb),
    .col_punch(m_punch));

  always #25 hclk = ~hclk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask : xf

  task btn(input logic [5:0] b);
    pnl <= b;
    @(posedge hclk);
    pnl <= 6'h00;
    @(posedge hclk);
  endtask : btn

  task card(input logic [11:0] p);
    mp <= p;
    xf(1'b1, ADDR_CTRL, 32'h0000_0003);
    for (i = 0; i < 100 && ccv !== 1'b1; i++) @(posedge hclk);
    c = col_char;
    for (i = 0; i < 100 && m_pass !== 1'b1; i++) @(posedge hclk);
    cyc(2);
  endtask : card

  task t_reset;
    xf(1'b0, ADDR_STATUS, 32'h0);
    chk(v[ST_UNAVAIL], 1'b1);
    chk(v[ST_LOGIC], 1'b0);
    chk(ru, 1'b1);
    xf(1'b0, 8'h20, 32'h0);
    chk(v, WORD_ZERO);
    chk(hresp, HRESP_OKAY);
    xf(1'b0, ADDR_IRQ_MASK, 32'h0);
    chk(v, WORD_ZERO);
    xf(1'b1, ADDR_IRQ_MASK, 32'h0000_000f);
  endtask : t_reset

  task t_power;
    btn(6'h20);
    chk(drive.supply_on, 1'b1);
    chk(drive.motor_on, 1'b1);
    btn(6'h08);
    chk(ru, 1'b1);
    xf(1'b0, ADDR_STATUS, 32'h0);
    chk(v[ST_LOGIC], 1'b0);
    cyc(12);
    xf(1'b0, ADDR_STATUS, 32'h0);
    chk(v[ST_LOGIC], 1'b1);
  endtask : t_power

  task t_start;
    sn.hopper_empty <= 1'b1;
    btn(6'h08);
    chk(ru, 1'b1);
    sn.hopper_empty <= 1'b0;
    cyc(1);
    btn(6'h08);
    chk(ru, 1'b0);
    sn.stacker_full <= 1'b1;
    cyc(2);
    chk(ru, 1'b1);
    sn.stacker_full <= 1'b0;
    cyc(2);
  endtask : t_start

  task t_card;
    card(12'h001);
    chk(c, 12'h001);
    chk(irq, 1'b1);
    xf(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(v[IRQ_DONE], 1'b1);
    xf(1'b1, ADDR_IRQ_STAT, 32'h0000_0008);
    cyc(1);
    chk(irq, 1'b0);
    xf(1'b0, ADDR_DATA, 32'h0);
    chk(v[11:0], 12'h001);
  endtask : t_card

  task t_badp;
    card(12'h003);
    chk(c, CHR_ZERO);
    xf(1'b0, ADDR_STATUS, 32'h0);
    chk(v[ST_BADP], 1'b0);
    chk(ru, 1'b0);
    sn.bad_punch_check_enable <= 1'b1;
    card(12'h003);
    chk(drive.error_lamp, 1'b1);
    xf(1'b0, ADDR_STATUS, 32'h0);
    chk(v[ST_ERROR] & v[ST_BADP] & ru, 1'b1);
    xf(1'b1, ADDR_CTRL, 32'h0000_0003);
    cyc(3);
    chk(drive.feed_clutch, 1'b0);
    sn.bad_punch_check_enable <= 1'b0;
    btn(6'h02);
    chk(drive.error_lamp, 1'b0);
    xf(1'b1, ADDR_IRQ_STAT, 32'h0000_000f);
    btn(6'h08);
    chk(ru, 1'b0);
  endtask : t_badp

  task t_feed;
    ad <= 8'h00;
    xf(1'b1, ADDR_CTRL, 32'h0000_0001);
    for (i = 0; i < 100 && drive.pi_request !== 1'b1; i++) @(posedge hclk);
    chk(32'(i >= 18 && i <= 24), 1'b1);
    chk(drive.attention_lamp & irq, 1'b1);
    chk(drive.motor_on, 1'b0);
    xf(1'b0, ADDR_STATUS, 32'h0);
    chk(v[ST_FEED] & v[ST_UNAVAIL], 1'b1);
    btn(6'h02);
    chk(drive.pi_request, 1'b0);
    chk(irq, 1'b1);
    xf(1'b1, ADDR_IRQ_STAT, 32'h0000_000f);
    cyc(1);
    chk(irq, 1'b0);
    xf(1'b1, ADDR_CTRL, 32'h0000_0001);
    cyc(2);
    sn.select_fail <= 1'b1;
    cyc(1);
    sn.select_fail <= 1'b0;
    cyc(1);
    chk(drive.pi_request, 1'b1);
    btn(6'h02);
    xf(1'b1, ADDR_IRQ_STAT, 32'h0000_000f);
    ad <= 8'h03;
    btn(6'h08);
  endtask : t_feed

  task t_sense;
    sn.read_circuit_fault <= 1'b1;
    cyc(3);
    chk(drive.error_lamp & ru, 1'b1);
    xf(1'b0, ADDR_STATUS, 32'h0);
    chk(v[ST_ERROR], 1'b1);
    chk(v[ST_SENSE], 1'b1);
    sn.read_circuit_fault <= 1'b0;
    btn(6'h02);
    xf(1'b1, ADDR_IRQ_STAT, 32'h0000_000f);
    btn(6'h08);
    chk(ru, 1'b0);
  endtask : t_sense

  task t_stop;
    xf(1'b1, ADDR_CTRL, 32'h0000_0001);
    for (i = 0; i < 100 && m_at !== 1'b1; i++) @(posedge hclk);
    sn.read_circuit_fault <= 1'b1;
    btn(6'h04);
    chk(ru, 1'b1);
    xf(1'b0, ADDR_STATUS, 32'h0);
    sn.read_circuit_fault <= 1'b0;
    chk(v[ST_SENSE], 1'b0);
    chk(v[ST_BUSY], 1'b1);
    for (i = 0; i < 100 && m_pass !== 1'b1; i++) @(posedge hclk);
    chk(m_pass, 1'b1);
    cyc(3);
    chk(drive.feed_clutch, 1'b0);
    xf(1'b1, ADDR_IRQ_STAT, 32'h0000_000f);
    btn(6'h08);
  endtask : t_stop

  task t_eof;
    sn.hopper_empty <= 1'b1;
    btn(6'h01);
    xf(1'b0, ADDR_STATUS, 32'h0);
    chk(v[ST_EOF], 1'b1);
    chk(drive.attention_lamp & irq, 1'b1);
    sn.hopper_empty <= 1'b0;
    cyc(2);
    xf(1'b0, ADDR_STATUS, 32'h0);
    chk(v[ST_EOF], 1'b0);
    xf(1'b1, ADDR_IRQ_STAT, 32'h0000_000f);
    btn(6'h08);
  endtask : t_eof

  task t_local;
    sn.standalone_feed_switch <= 1'b1;
    for (i = 0; i < 100 && m_pass !== 1'b1; i++) @(posedge hclk);
    chk(m_pass, 1'b1);
    sn.hopper_empty <= 1'b1;
    for (i = 0; i < 100 && drive.pi_request !== 1'b1; i++) @(posedge hclk);
    xf(1'b0, ADDR_STATUS, 32'h0);
    chk(v[ST_FEED], 1'b1);
    btn(6'h10);
    chk(drive.supply_on, 1'b0);
    chk(ru, 1'b1);
    sn.system_power <= 1'b1;
    cyc(2);
    chk(drive.supply_on, 1'b1);
    cyc(12);
    xf(1'b0, ADDR_STATUS, 32'h0);
    chk(v[ST_LOGIC], 1'b1);
  endtask : t_local

  task finish_test;
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #2_000_000;
    n_fail++;
    finish_test;
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    pnl = 6'h00;
    sn = '0;
    mp = 12'h000;
    ad = 8'h03;
    n_fail = 0;
    comparisons = 0;
    cyc(6);
    hresetn <= 1'b1;
    cyc(1);
    t_reset;
    t_power;
    t_start;
    t_card;
    t_badp;
    t_feed;
    t_sense;
    t_stop;
    t_eof;
    t_local;
    finish_test;
  end
endmodule : test_card_reader_status_control
`default_nettype wire

// ===== logic/crd_ctrl.sv
// card reader control and status logic with an ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
module crd_ctrl #(
  parameter int unsigned PWRUP_CYC = crd_pkg::PWRUP_CYC,
  parameter int unsigned FEED_CYC = crd_pkg::FEED_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  input wire crd_pkg::crd_panel_t panel,
  input wire crd_pkg::crd_sense_t sense,
  input wire logic col_strobe,
  input wire logic [11:0] col_punch,
  output logic [11:0] col_char,
  output logic col_char_valid,
  output crd_pkg::crd_drive_t drive,
  output logic reader_unavailable,
  output logic irq
);
  import crd_pkg::*;

  localparam logic [CNT_W-1:0] PWRUP_LIM = CNT_W'(PWRUP_CYC - 1);
  localparam logic [CNT_W-1:0] FEED_LIM = CNT_W'(FEED_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  crd_regs_t r_ff;
  crd_regs_t nxt_r;

  // rows 12,11,0 in bits 11:9, rows 1..9 in bits 0..8
  function automatic logic punch_ok(input logic [11:0] p);
    logic [2:0] zn;
    logic [8:0] dg;
    logic dg_ok;
    zn = p[11:9];
    dg = p[8:0];
    dg_ok = ($countones(dg) <= 1) ||
            (($countones(dg) == 2) && dg[7] && (|dg[6:1]));
    return ($countones(zn) <= 1) && dg_ok;
  endfunction : punch_ok

  logic faults;
  logic unavail;
  logic status_err;
  logic acc;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic [IRQ_W-1:0] ev;

  assign faults = r_ff.sense_f | r_ff.feed_f | r_ff.badp_f;
  // any not-ready condition, checks and power included
  assign unavail = !r_ff.started | sense.hopper_empty |
                   sense.stacker_full | faults | !r_ff.supply |
                   !r_ff.logic_en;
  assign status_err = r_ff.sense_f | r_ff.badp_f;
  assign acc = hsel & hready & htrans[1];

  always_comb begin
    status_word = WORD_ZERO;
    status_word[ST_UNAVAIL] = unavail;
    status_word[ST_ERROR] = status_err;
    status_word[ST_FEED] = r_ff.feed_f;
    status_word[ST_EOF] = r_ff.eof;
    status_word[ST_SENSE] = r_ff.sense_f;
    status_word[ST_BADP] = r_ff.badp_f;
    status_word[ST_BUSY] = (r_ff.st != CS_IDLE);
    status_word[ST_LOGIC] = r_ff.logic_en;
  end

  // read data is picked in the address phase
  always_comb begin
    rd_mux = WORD_ZERO;
    if (haddr[7:0] == ADDR_CTRL) begin
      rd_mux[CTRL_ALNUM] = r_ff.alnum;
      rd_mux[CTRL_REQ] = r_ff.req;
    end else if (haddr[7:0] == ADDR_STATUS) begin
      rd_mux = status_word;
    end else if (haddr[7:0] == ADDR_IRQ_STAT) begin
      rd_mux[IRQ_W-1:0] = r_ff.irq_st;
    end else if (haddr[7:0] == ADDR_IRQ_MASK) begin
      rd_mux[IRQ_W-1:0] = r_ff.irq_mask;
    end else if (haddr[7:0] == ADDR_DATA) begin
      rd_mux[11:0] = r_ff.chr;
    end
  end

  always_comb begin
    nxt_r = r_ff;
    ev = IRQ_RST;
    nxt_r.chr_vld = 1'b0;
    nxt_r.sys_pwr_q = sense.system_power;

    // bus phases
    nxt_r.ph_act = acc;
    if (acc) begin
      nxt_r.ph_wr = hwrite;
      nxt_r.ph_addr = haddr[7:0];
      if (!hwrite) begin
        nxt_r.rdata = rd_mux;
      end
    end

    // power and delayed control enable
    if (panel.power_up || (sense.system_power && !r_ff.sys_pwr_q)) begin
      nxt_r.supply = 1'b1;
    end else if (panel.power_off) begin
      nxt_r.supply = 1'b0;
    end
    if (!r_ff.supply) begin
      nxt_r.logic_en = 1'b0;
      nxt_r.pcnt = CNT_ZERO;
    end else if (!r_ff.logic_en) begin
      if (r_ff.pcnt == PWRUP_LIM) begin
        nxt_r.logic_en = 1'b1;
      end else begin
        nxt_r.pcnt = r_ff.pcnt + CNT_ONE;
      end
    end

    // start and stop
    if (panel.stop || !r_ff.supply) begin
      nxt_r.started = 1'b0;
    end else if (panel.start && r_ff.logic_en && !faults &&
                 !sense.hopper_empty && !sense.stacker_full) begin
      nxt_r.started = 1'b1;
    end

    // operator reset of the checks; hardware sets below win
    if (panel.reset) begin
      nxt_r.sense_f = 1'b0;
      nxt_r.feed_f = 1'b0;
      nxt_r.badp_f = 1'b0;
    end

    // read circuit checking suppressed during card cycles
    if (sense.read_circuit_fault && r_ff.logic_en &&
        r_ff.st == CS_IDLE) begin
      nxt_r.sense_f = 1'b1;
    end

    // last_card_marker latch, cleared by loading cards
    if (!sense.hopper_empty) begin
      nxt_r.eof = 1'b0;
    end
    if (panel.last_card_marker && sense.hopper_empty) begin
      nxt_r.eof = 1'b1;
    end

    // register writes in the data phase
    if (r_ff.ph_act && r_ff.ph_wr) begin
      if (r_ff.ph_addr == ADDR_CTRL) begin
        nxt_r.alnum = hwdata[CTRL_ALNUM];
        if (hwdata[CTRL_REQ] && !unavail &&
            !sense.standalone_feed_switch) begin
          nxt_r.req = 1'b1;
        end
      end else if (r_ff.ph_addr == ADDR_IRQ_STAT) begin
        nxt_r.irq_st = r_ff.irq_st & ~hwdata[IRQ_W-1:0];
      end else if (r_ff.ph_addr == ADDR_IRQ_MASK) begin
        nxt_r.irq_mask = hwdata[IRQ_W-1:0];
      end
    end
    if (unavail || sense.standalone_feed_switch) begin
      nxt_r.req = 1'b0;
    end

    // card cycle
    case (r_ff.st)
      CS_IDLE: begin
        nxt_r.fcnt = CNT_ZERO;
        if (sense.standalone_feed_switch) begin
          if (sense.hopper_empty && r_ff.started && r_ff.logic_en &&
              !faults) begin
            nxt_r.feed_f = 1'b1;
          end else if (!unavail) begin
            nxt_r.st = CS_FEED;
          end
        end else if (r_ff.req && !unavail) begin
          nxt_r.st = CS_FEED;
          nxt_r.req = 1'b0;
        end
      end
      CS_FEED: begin
        nxt_r.fcnt = r_ff.fcnt + CNT_ONE;
        if (sense.select_fail) begin
          nxt_r.feed_f = 1'b1;
          nxt_r.st = CS_IDLE;
        end else if (sense.card_at_station) begin
          nxt_r.st = CS_READ;
        end else if (r_ff.fcnt == FEED_LIM) begin
          nxt_r.feed_f = 1'b1;
          nxt_r.st = CS_IDLE;
        end
      end
      CS_READ: begin
        // no timeout here: a card stuck in the station just waits
        if (col_strobe) begin
          nxt_r.chr_vld = 1'b1;
          if (r_ff.alnum && !punch_ok(col_punch)) begin
            nxt_r.chr = CHR_ZERO;
            if (sense.bad_punch_check_enable) begin
              nxt_r.badp_f = 1'b1;
            end
          end else begin
            nxt_r.chr = col_punch;
          end
        end
        if (sense.card_passed) begin
          nxt_r.st = CS_IDLE;
          ev[IRQ_DONE] = 1'b1;
        end
      end
      default: begin
        nxt_r.st = CS_IDLE;
      end
    endcase

    if (!r_ff.supply) begin
      nxt_r.st = CS_IDLE;
    end

    // sticky events, set wins over a write-one clear
    ev[IRQ_FEED] = nxt_r.feed_f & !r_ff.feed_f;
    ev[IRQ_EOF] = nxt_r.eof & !r_ff.eof;
    ev[IRQ_ERR] = (nxt_r.sense_f & !r_ff.sense_f) |
                  (nxt_r.badp_f & !r_ff.badp_f);
    nxt_r.irq_st = nxt_r.irq_st | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = r_ff.rdata;
  assign col_char = r_ff.chr;
  assign col_char_valid = r_ff.chr_vld;
  assign reader_unavailable = unavail;
  assign drive.supply_on = r_ff.supply;
  assign drive.motor_on = r_ff.supply & !r_ff.feed_f;
  assign drive.feed_clutch = (r_ff.st == CS_FEED);
  assign drive.error_lamp = status_err;
  assign drive.attention_lamp = r_ff.feed_f | r_ff.eof;
  // channel request held while its cause stands
  assign drive.pi_request = r_ff.feed_f | r_ff.eof;
  assign irq = |(r_ff.irq_st & r_ff.irq_mask);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_unavail_power: assert property (
    !r_ff.supply |-> reader_unavailable)
    else $error("unavailable low with power off");
  a_unavail_fault: assert property (faults |-> reader_unavailable)
    else $error("unavailable low with a fault");
  a_no_cycle_unavail: assert property (
    (r_ff.st == CS_IDLE && reader_unavailable) |=> r_ff.st == CS_IDLE)
    else $error("card cycle began while unavailable");
  a_sense_suppress: assert property (
    (r_ff.st != CS_IDLE && !r_ff.sense_f) |=> !r_ff.sense_f)
    else $error("read check raised during card cycle");
  a_sense_error: assert property (
    (r_ff.logic_en && r_ff.st == CS_IDLE && sense.read_circuit_fault)
    |=> r_ff.sense_f && drive.error_lamp && reader_unavailable)
    else $error("read malfunction not flagged");
  a_feed_motor: assert property (
    r_ff.feed_f |-> !drive.motor_on && drive.attention_lamp &&
                    drive.pi_request)
    else $error("feed fault effects missing");
  a_feed_timeout: assert property (
    (r_ff.st == CS_FEED && r_ff.fcnt == FEED_LIM &&
     !sense.card_at_station) |=> r_ff.feed_f && r_ff.st == CS_IDLE)
    else $error("feed timeout missed");
  a_zero_char: assert property (
    (r_ff.st == CS_READ && col_strobe && r_ff.alnum &&
     !punch_ok(col_punch)) |=> col_char_valid && col_char == CHR_ZERO)
    else $error("invalid punch not zeroed");
  a_badp_set: assert property (
    (r_ff.st == CS_READ && col_strobe && r_ff.alnum &&
     !punch_ok(col_punch) && sense.bad_punch_check_enable)
    |=> r_ff.badp_f && drive.error_lamp && status_word[ST_ERROR])
    else $error("bad punch not flagged");
  a_badp_off: assert property (
    (!sense.bad_punch_check_enable && !r_ff.badp_f) |=> !r_ff.badp_f)
    else $error("bad punch fault while checking off");
  a_pwrup_delay: assert property (
    $rose(r_ff.logic_en) |-> $past(r_ff.pcnt) == PWRUP_LIM)
    else $error("control enabled before delay");
  a_start_blocked: assert property (
    (panel.start && sense.hopper_empty) |=> !r_ff.started)
    else $error("start cleared unavailable with hopper empty");
  a_stop_now: assert property (panel.stop |=> reader_unavailable)
    else $error("stop did not make reader unavailable");
  a_reset_faults: assert property (
    (panel.reset && ((r_ff.st == CS_READ && !col_strobe) ||
     (r_ff.st == CS_IDLE && !sense.read_circuit_fault &&
      !sense.standalone_feed_switch)))
    |=> !r_ff.feed_f && !r_ff.badp_f && !r_ff.sense_f)
    else $error("reset left a fault set");
  a_eof_latch: assert property (
    (panel.last_card_marker && sense.hopper_empty)
    |=> r_ff.eof && drive.attention_lamp && drive.pi_request)
    else $error("last_card_marker not latched");
  a_jam_no_feed: assert property (
    (r_ff.st == CS_READ && !r_ff.feed_f) |=> !r_ff.feed_f)
    else $error("feed fault raised during read");
  a_irq_held: assert property (
    (r_ff.irq_st[IRQ_FEED] && r_ff.irq_mask[IRQ_FEED] &&
     !(r_ff.ph_act && r_ff.ph_wr)) |=> irq)
    else $error("interrupt dropped without a clear");
  a_req_refused: assert property (reader_unavailable |=> !r_ff.req)
    else $error("card request kept while unavailable");
  a_select_fault: assert property (
    (r_ff.st == CS_FEED && sense.select_fail)
    |=> r_ff.feed_f && r_ff.st == CS_IDLE && reader_unavailable)
    else $error("select failure not flagged");
  a_feed_irq: assert property (
    $rose(r_ff.feed_f) |-> r_ff.irq_st[IRQ_FEED] && drive.pi_request)
    else $error("feed fault raised no interrupt");
  a_power_motor: assert property (
    panel.power_up |=> drive.supply_on && (drive.motor_on || r_ff.feed_f))
    else $error("power up left supply or motors off");
  a_logic_off: assert property (!r_ff.supply |=> !r_ff.logic_en)
    else $error("control logic enabled without power");
  a_start_ok: assert property (
    (panel.start && !panel.stop && r_ff.supply && r_ff.logic_en &&
     !faults && !sense.hopper_empty && !sense.stacker_full)
    |=> r_ff.started)
    else $error("start refused with reader ready");
  a_card_finish: assert property (
    (r_ff.st == CS_READ && !sense.card_passed && r_ff.supply)
    |=> r_ff.st == CS_READ)
    else $error("card cycle cut short");
  a_eof_clear: assert property (!sense.hopper_empty |=> !r_ff.eof)
    else $error("last_card_marker kept with cards loaded");
  a_local_empty: assert property (
    (r_ff.st == CS_IDLE && sense.standalone_feed_switch &&
     sense.hopper_empty && r_ff.started && r_ff.logic_en && !faults)
    |=> r_ff.feed_f)
    else $error("standalone feed did not stop on empty hopper");

  c_card_read: cover property (r_ff.st == CS_READ ##1 r_ff.st == CS_IDLE);
  c_feed_fault: cover property ($rose(r_ff.feed_f));
  c_bad_punch: cover property ($rose(r_ff.badp_f));
  c_eof: cover property ($rose(r_ff.eof));
  c_local: cover property (sense.standalone_feed_switch && r_ff.st == CS_READ);

endmodule : crd_ctrl
`default_nettype wire

// ===== pkg/crd_pkg.sv
// package: constants, field layout and carrier types of the card reader control
package crd_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned PWRUP_DELAY_MS = 3000;
  localparam int unsigned FEED_TIMEOUT_MS = 100;
  localparam int unsigned PWRUP_CYC = (CLK_HZ / 1000) * PWRUP_DELAY_MS;
  localparam int unsigned FEED_CYC = (CLK_HZ / 1000) * FEED_TIMEOUT_MS;
  localparam int unsigned CNT_W = 26;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_DATA = 8'h10;

  localparam int unsigned CTRL_REQ = 0;
  localparam int unsigned CTRL_ALNUM = 1;

  localparam int unsigned ST_UNAVAIL = 0;
  localparam int unsigned ST_ERROR = 1;
  localparam int unsigned ST_FEED = 2;
  localparam int unsigned ST_EOF = 3;
  localparam int unsigned ST_SENSE = 4;
  localparam int unsigned ST_BADP = 5;
  localparam int unsigned ST_BUSY = 6;
  localparam int unsigned ST_LOGIC = 7;

  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_FEED = 0;
  localparam int unsigned IRQ_EOF = 1;
  localparam int unsigned IRQ_ERR = 2;
  localparam int unsigned IRQ_DONE = 3;

  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
  localparam logic [11:0] CHR_ZERO = 12'h000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef enum logic [1:0] {CS_IDLE, CS_FEED, CS_READ} crd_state_t;

  // operator panel, one-cycle pulses
  typedef struct packed {
    logic power_up;
    logic power_off;
    logic start;
    logic stop;
    logic reset;
    logic last_card_marker;
  } crd_panel_t;

  // mechanism sensors and switches, levels unless noted
  typedef struct packed {
    logic system_power;
    logic hopper_empty;
    logic stacker_full;
    logic read_circuit_fault;
    logic card_at_station;
    logic select_fail;
    logic card_passed;
    logic standalone_feed_switch;
    logic bad_punch_check_enable;
  } crd_sense_t;

  typedef struct packed {
    logic supply_on;
    logic motor_on;
    logic feed_clutch;
    logic error_lamp;
    logic attention_lamp;
    logic pi_request;
  } crd_drive_t;

  typedef struct packed {
    crd_state_t st;
    logic sys_pwr_q;
    logic supply;
    logic logic_en;
    logic [CNT_W-1:0] pcnt;
    logic [CNT_W-1:0] fcnt;
    logic started;
    logic sense_f;
    logic feed_f;
    logic badp_f;
    logic eof;
    logic alnum;
    logic req;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic [11:0] chr;
    logic chr_vld;
    logic ph_act;
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
  } crd_regs_t;

endpackage : crd_pkg
